// ### rtl/sps_port.sv
/*
 * full-duplex serial port, master or slave, with axi4-lite register slave.
 * assumes serial pins already synchronous to aclk; external master keeps
 * its clock at or below aclk/8. pin output enables are active low.
 */
// Overview of operation
// - buffer write while busy is dropped, transfer continues, collision flag set
// - data writes go to shift register, data reads return receive buffer
// - master and enabled: data write starts a transfer at once
// - master shifts msb first out, samples miso into lsb, drives clock
// - busy flag high from transfer start until completion
// - at end copy shift register to receive buffer, clear busy, set done
// - one enable bit gates the four event flags onto the interrupt
// - event flags stick until written 0; software write 1 raises irq
// - receive buffer unread at completion sets overrun, new data lost
// - master with fault detect: select falling edge sets fault, drops master
// - select ignored in master without detect; always select in slave
// - master bit may rise only while select is deasserted
// - enable bit off stops both the port and its clock generator
// - config picks length, sampling edge and clock idle level
// - master clock is aclk/2/(divider+1); divider unused in slave
// - slave sends what the shift register holds when a cycle starts
// - unselected slave ignores clock, does not shift, releases miso
// - select lost mid-character aborts: no load, no done, counter reset
// - slave format and length should match the master
// - slave shifts msb first on miso, takes mosi in until done
// - mode fault also clears the enable bit
// - 8-bit characters use the low byte for send and receive
`timescale 1ns/1ps
`include "sps_params.svh"

module sps_port (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire sps_pkg::sps_pins_in_s pins_in,
	output sps_pkg::sps_pins_out_s    pins_out,
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0]          ctrl_q;
	logic [7:0]          cfg_q;
	logic [7:0]          div_q;
	logic [15:0]         shift_q;
	logic [15:0]         rxbuf_q;
	logic                rx_unread_q;
	sps_pkg::sps_state_e state_q;
	logic [7:0]          tick_q;
	logic [4:0]          bits_q;
	logic                half_q;
	logic                sck_q;
	logic                sck_prev_q;
	logic                ssel_prev_q;
	logic                mosi_q;
	logic                have_aw_q;
	logic                have_w_q;
	logic [7:0]          aw_q;
	logic [31:0]         w_q;
	logic [3:0]          ws_q;

	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		if (a == `SPS_OFF_CTRL) begin
			reg_sel = 2'h0;
		end else if (a == `SPS_OFF_CFG) begin
			reg_sel = 2'h1;
		end else if (a == `SPS_OFF_DIV) begin
			reg_sel = 2'h2;
		end else begin
			reg_sel = 2'h3;
		end
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `SPS_OFF_CTRL) || (a == `SPS_OFF_CFG) ||
			(a == `SPS_OFF_DIV) || (a == `SPS_OFF_DATA);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	logic wr_go;
	logic wr_ok;
	logic [1:0] wr_sel;
	logic wr_lo;

	assign s_axi_awready = !have_aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !have_w_q && !s_axi_bvalid;
	assign wr_go  = have_aw_q && have_w_q && !s_axi_bvalid;
	assign wr_ok  = is_mapped(aw_q);
	assign wr_sel = reg_sel(aw_q);
	assign wr_lo  = wr_go && wr_ok && ws_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw_q <= 1'b0;
			have_w_q  <= 1'b0;
			aw_q      <= 8'h00;
			w_q       <= 32'h0000_0000;
			ws_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end else if (wr_go) begin
				have_aw_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w_q <= 1'b1;
				w_q      <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end else if (wr_go) begin
				have_w_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SPS_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel
	logic rd_go;
	logic rd_data;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go   = s_axi_arvalid && s_axi_arready;
	assign rd_data = rd_go && (s_axi_araddr == `SPS_OFF_DATA);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SPS_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= is_mapped(s_axi_araddr) ?
				`SPS_RESP_OKAY : `SPS_RESP_SLVERR;
			if (!is_mapped(s_axi_araddr)) begin
				s_axi_rdata <= 32'h0000_0000;
			end else if (reg_sel(s_axi_araddr) == 2'h0) begin
				s_axi_rdata <= {24'h000000, ctrl_q};
			end else if (reg_sel(s_axi_araddr) == 2'h1) begin
				s_axi_rdata <= {24'h000000, cfg_q[7], 4'h0, cfg_q[2:0]};
			end else if (reg_sel(s_axi_araddr) == 2'h2) begin
				s_axi_rdata <= {24'h000000, div_q};
			end else begin
				s_axi_rdata <= {16'h0000, rxbuf_q};
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial engine decode
	logic en;
	logic mstr;
	logic cpha;
	logic cpol;
	logic [4:0] nbits;
	logic ssel_fall;
	logic fault;
	logic sel;
	logic busy;
	logic sck_in;
	logic s_rise;
	logic s_fall;
	logic s_lead;
	logic s_trail;
	logic s_sample;
	logic m_tick;
	logic m_sample;
	logic m_shift;
	logic last_bit;
	logic done;
	logic abort;
	logic data_wr;
	logic start_m;

	assign en    = ctrl_q[`SPS_CTL_EN];
	assign mstr  = ctrl_q[`SPS_CTL_MSTR];
	assign cpha  = cfg_q[`SPS_CFG_CPHA];
	assign cpol  = cfg_q[`SPS_CFG_CPOL];
	assign nbits = cfg_q[`SPS_CFG_CHR] ? `SPS_BITS_16 : `SPS_BITS_8;
	assign busy  = state_q != sps_pkg::SPS_IDLE;
	assign ssel_fall = ssel_prev_q && !pins_in.ssel_n;
	assign fault = en && mstr && ctrl_q[`SPS_CTL_FDE] && ssel_fall;
	assign sel   = en && !mstr && !pins_in.ssel_n;

	// slave clock edges relative to idle level
	assign sck_in  = pins_in.sck ^ cpol;
	assign s_rise  = sck_in && !sck_prev_q;
	assign s_fall  = !sck_in && sck_prev_q;
	assign s_lead  = sel && s_rise;
	assign s_trail = sel && s_fall;
	assign s_sample = cpha ? s_trail : s_lead;

	// master: toggle every divider+1 cycles -> aclk/2/(div+1)
	assign m_tick   = (state_q == sps_pkg::SPS_MRUN) && (tick_q == div_q);
	assign m_sample = m_tick && (half_q == cpha);
	assign m_shift  = m_tick && (half_q != cpha);

	assign last_bit = bits_q == nbits - 5'h01;
	assign done = (state_q == sps_pkg::SPS_MRUN) ? (m_tick && half_q &&
		last_bit) : ((state_q == sps_pkg::SPS_SRUN) && sel &&
		(cpha ? s_trail : s_lead) && last_bit);
	assign abort = (state_q == sps_pkg::SPS_SRUN) && !sel;
	assign data_wr = wr_go && wr_ok && (wr_sel == 2'h3);
	assign start_m = data_wr && !busy && en && mstr;

	////////////////////////////////////////////////////////////////////////
	// transfer sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= sps_pkg::SPS_IDLE;
			tick_q  <= 8'h00;
			bits_q  <= 5'h00;
			half_q  <= 1'b0;
			sck_q   <= 1'b0;
		end else if (!en || fault) begin
			state_q <= sps_pkg::SPS_IDLE;
			tick_q  <= 8'h00;
			bits_q  <= 5'h00;
			half_q  <= 1'b0;
			sck_q   <= 1'b0;
		end else begin
			case (state_q)
				sps_pkg::SPS_IDLE: begin
					tick_q <= 8'h00;
					bits_q <= 5'h00;
					half_q <= 1'b0;
					sck_q  <= 1'b0;
					if (start_m) begin
						state_q <= sps_pkg::SPS_MRUN;
					end else if (sel && (ssel_fall || s_rise)) begin
						state_q <= sps_pkg::SPS_SRUN;
						if (s_rise && !cpha) begin
							bits_q <= 5'h00;
						end
					end
				end
				sps_pkg::SPS_MRUN: begin
					tick_q <= m_tick ? 8'h00 : tick_q + 8'h01;
					if (m_tick) begin
						half_q <= !half_q;
						sck_q  <= !sck_q;
						if (half_q) begin
							bits_q <= bits_q + 5'h01;
						end
					end
					if (done) begin
						state_q <= sps_pkg::SPS_IDLE;
					end
				end
				default: begin
					if (abort || done) begin
						state_q <= sps_pkg::SPS_IDLE;
						bits_q  <= 5'h00;
					end else if (cpha ? s_trail : s_lead) begin
						bits_q <= bits_q + 5'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_prev_q  <= 1'b0;
			ssel_prev_q <= 1'b1;
		end else begin
			sck_prev_q  <= sel ? sck_in : 1'b0;
			ssel_prev_q <= pins_in.ssel_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shift register and receive buffer
	logic [3:0] msb_idx;
	logic       rx_bit;
	logic [15:0] rx_word;

	assign msb_idx = cfg_q[`SPS_CFG_CHR] ? 4'hF : 4'h7;
	assign rx_bit  = mstr ? pins_in.miso : pins_in.mosi;
	// master with active-edge sampling ends on a shift edge: word complete
	assign rx_word = (state_q == sps_pkg::SPS_MRUN && !cpha) ? shift_q :
		{shift_q[14:0], rx_bit};

	// mosi moves only on an idle data write and on shift edges, never under the slave's sample edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mosi_q <= 1'b0;
		end else if (data_wr && !busy) begin
			mosi_q <= w_q[msb_idx];
		end else if (m_shift) begin
			mosi_q <= shift_q[msb_idx];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= `SPS_RST_DATA;
		end else if (data_wr && !busy) begin
			shift_q <= w_q[15:0];
		end else if ((m_sample || (state_q == sps_pkg::SPS_SRUN &&
				(cpha ? s_trail : s_lead))) ||
				(state_q == sps_pkg::SPS_IDLE && sel && !cpha &&
				s_rise)) begin
			shift_q <= {shift_q[14:0], rx_bit};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxbuf_q     <= `SPS_RST_DATA;
			rx_unread_q <= 1'b0;
		end else if (done && !(rx_unread_q && !rd_data)) begin
			rxbuf_q     <= cfg_q[`SPS_CFG_CHR] ? rx_word :
				{8'h00, rx_word[7:0]};
			rx_unread_q <= 1'b1;
		end else if (rd_data) begin
			rx_unread_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control, config, divider registers
	logic [7:0] ctl_wv;

	assign ctl_wv = w_q[7:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `SPS_RST_CTRL;
		end else begin
			ctrl_q[`SPS_CTL_BUSY] <= busy && !done && !abort;
			if (wr_lo && wr_sel == 2'h0) begin
				ctrl_q[6:2] <= ctl_wv[6:2];
				ctrl_q[`SPS_CTL_EN] <= ctl_wv[`SPS_CTL_EN];
				if (!ctl_wv[`SPS_CTL_MSTR] || mstr ||
						pins_in.ssel_n) begin
					ctrl_q[`SPS_CTL_MSTR] <= ctl_wv[`SPS_CTL_MSTR];
				end
			end
			// hardware sets win over software clears
			if (done) begin
				ctrl_q[`SPS_CTL_DONE] <= 1'b1;
			end
			if (done && rx_unread_q && !rd_data) begin
				ctrl_q[`SPS_CTL_OVR] <= 1'b1;
			end
			if (data_wr && busy) begin
				ctrl_q[`SPS_CTL_WRITE_COLLIDE_FLAG] <= 1'b1;
			end
			if (fault) begin
				ctrl_q[`SPS_CTL_MODE_FAULT_FLAG] <= 1'b1;
				ctrl_q[`SPS_CTL_MSTR] <= 1'b0;
				ctrl_q[`SPS_CTL_EN]   <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= `SPS_RST_CFG;
			div_q <= `SPS_RST_DIV;
		end else if (wr_lo && wr_sel == 2'h1) begin
			cfg_q <= {ctl_wv[7], 4'h0, ctl_wv[2:0]};
		end else if (wr_lo && wr_sel == 2'h2) begin
			div_q <= ctl_wv;
		end
	end

	assign irq = cfg_q[`SPS_CFG_IRQE] && (|ctrl_q[6:3]);

	////////////////////////////////////////////////////////////////////////
	// pins
	assign pins_out.sck      = sck_q ^ cpol;
	assign pins_out.sck_oe_n = !(en && mstr);
	assign pins_out.mosi     = mosi_q;
	assign pins_out.mosi_oe_n = !(en && mstr);
	assign pins_out.miso     = shift_q[msb_idx];
	assign pins_out.miso_oe_n = !sel;

endmodule

// ### shared/sps_params.svh
/*
 * constants for the serial port: register offsets, bit positions, resets,
 * bus responses, character lengths.
 * assumes inclusion by bare name from design file and testbench.
 */
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// byte addresses on the register bus (chosen)
`define SPS_OFF_CTRL       8'h00
`define SPS_OFF_CFG        8'h04
`define SPS_OFF_DIV        8'h08
`define SPS_OFF_DATA       8'h0C

// control register bit positions
`define SPS_CTL_BUSY       7
`define SPS_CTL_DONE       6
`define SPS_CTL_OVR        5
`define SPS_CTL_WRITE_COLLIDE_FLAG       4
`define SPS_CTL_MODE_FAULT_FLAG       3
`define SPS_CTL_FDE        2
`define SPS_CTL_MSTR       1
`define SPS_CTL_EN         0

// config register bit positions
`define SPS_CFG_IRQE       7
`define SPS_CFG_CHR        2
`define SPS_CFG_CPHA       1
`define SPS_CFG_CPOL       0

// reset values
`define SPS_RST_CTRL       8'h00
`define SPS_RST_CFG        8'h00
`define SPS_RST_DIV        8'h00
`define SPS_RST_DATA       16'h0000

// character lengths in bits
`define SPS_BITS_8         5'h08
`define SPS_BITS_16        5'h10

// responses
`define SPS_RESP_OKAY      2'h0
`define SPS_RESP_SLVERR    2'h2

`endif

// ### shared/sps_pkg.sv
/*
 * types for the serial port block.
 * assumes sps_params.svh is available on the include path.
 */
package sps_pkg;
	typedef enum logic [1:0] {
		SPS_IDLE,
		SPS_MRUN,
		SPS_SRUN
	} sps_state_e;

	typedef struct packed {
		logic mosi;
		logic sck;
		logic sck_oe_n;
		logic mosi_oe_n;
		logic miso;
		logic miso_oe_n;
	} sps_pins_out_s;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ssel_n;
	} sps_pins_in_s;
endpackage

// ### tb/sps_port_monitor.sv
/*
 * checker on the serial port's bus handshakes and pin enables.
 * assumes it is bound onto sps_port with port names matching.
 */
`timescale 1ns/1ps
module sps_port_monitor (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	input wire logic [31:0]            s_axi_rdata,
	input wire sps_pkg::sps_pins_in_s  pins_in,
	input wire sps_pkg::sps_pins_out_s pins_out,
	input wire logic                   irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_commit_then_resp;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_init;
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
			&& pins_out.sck_oe_n && pins_out.miso_oe_n;
	endproperty
	property p_wr_lat;
		s_wr_take |=> s_commit_then_resp;
	endproperty
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_ar_gate;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_aw_gate;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	property p_miso_rel;
		pins_in.ssel_n |-> pins_out.miso_oe_n;
	endproperty
	property p_one_role;
		!pins_out.miso_oe_n |-> pins_out.sck_oe_n && pins_out.mosi_oe_n;
	endproperty
	// undriven clock only moves after a register write (polarity change)
	property p_sck_rel;
		pins_out.sck_oe_n && $past(pins_out.sck_oe_n) &&
			$changed(pins_out.sck) |-> $rose(s_axi_bvalid);
	endproperty
	////////////////////////////////////////////////////////////////////////
	a_init: assert property (p_init)
		else $error("outputs not idle after reset");
	a_wr_lat: assert property (p_wr_lat)
		else $error("write response late or early");
	a_rd_lat: assert property (p_rd_lat)
		else $error("read data not one cycle after address");
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped before accept");
	a_ar_gate: assert property (p_ar_gate)
		else $error("read address taken with data pending");
	a_aw_gate: assert property (p_aw_gate)
		else $error("write address taken with response pending");
	a_miso_rel: assert property (p_miso_rel)
		else $error("miso driven while unselected");
	a_one_role: assert property (p_one_role)
		else $error("master and slave drivers on together");
	a_sck_rel: assert property (p_sck_rel)
		else $error("idle serial clock moved without a write");
endmodule

bind sps_port sps_port_monitor mon_u (.*);

// ### tb/sps_slave_model.sv
/*
 * far-side serial slave, clock idle low, sampling on rising edge.
 * assumes the bench selects it and reloads tx before each character.
 */
`timescale 1ns/1ps
module sps_slave_model (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic [7:0]      rx,
	output int              n_rise
);
	logic [7:0] sh_q;
	// msb goes out at select, so the first sample is valid
	always @(negedge sel_n) begin
		sh_q = tx;
		n_rise = 0;
	end
	always @(posedge sck) if (!sel_n) begin
		rx = {rx[6:0], mosi};
		n_rise++;
	end
	always @(negedge sck) if (!sel_n) sh_q = {sh_q[6:0], 1'b0};
	// line has a pull-up once released
	assign miso = sel_n ? 1'b1 : sh_q[7];
endmodule

// ### tb/testbench.sv
/*
 * self-checking bench: register bus, master and slave transfers, faults.
 * assumes the slave model and the checker are compiled beforehand.
 */
`timescale 1ns/1ps
`include "sps_params.svh"
module testbench;
	logic        aclk, aresetn, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_b, m_rx;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, lresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        t_sck, t_mosi, ssel_n, m_sel_n, m_miso;
	int          n_rise, hi_cyc, cyc, error_cnt, n_tests;
	sps_pkg::sps_pins_in_s  pins_in;
	sps_pkg::sps_pins_out_s pins_out;
	wire so = pins_out.miso_oe_n ? 1'b1 : pins_out.miso;
	assign pins_in = {t_sck, t_mosi, m_miso, ssel_n};
	sps_port dut_u (.*);
	sps_slave_model sm_u (.sck(pins_out.sck), .mosi(pins_out.mosi),
		.sel_n(m_sel_n), .tx(tx_b), .miso(m_miso), .rx(m_rx), .n_rise(n_rise));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (pins_out.sck && !pins_out.sck_oe_n) hi_cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			summarize;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// handshakes judged on settled values, half a period before the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			lresp = s_axi_bresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
		end while (!b_t);
		s_axi_bready <= 1'b0;
	endtask
	// ready raised a cycle late so data is seen waiting
	task automatic rd(input logic [7:0] a, output logic [31:0] g);
		logic t;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			g = s_axi_rdata;
			lresp = s_axi_rresp;
			@(posedge aclk);
		end while (!t);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
		logic [31:0] g;
		rd(a, g);
		chk($sformatf("reg %h", a), e, g & m);
	endtask
	task automatic idle;
		logic [31:0] g;
		do rd(`SPS_OFF_CTRL, g); while (g[7] !== 1'b0);
		n_tests++;
	endtask
	task automatic go(input logic [15:0] d, input logic [7:0] t);
		@(posedge aclk);
		tx_b <= t;
		m_sel_n <= 1'b1;
		@(posedge aclk);
		m_sel_n <= 1'b0;
		hi_cyc = 0;
		wr(`SPS_OFF_DATA, {16'h0, d});
	endtask
	// external master, clock at aclk/8, select held for the character
	task automatic spx(input logic [7:0] o, input int n, output logic [7:0] g);
		@(posedge aclk);
		ssel_n <= 1'b0;
		for (int i = 7; i > 7 - n; i--) begin
			t_mosi <= o[i];
			repeat (4) @(posedge aclk);
			t_sck <= 1'b1;
			g[i] = so;
			repeat (4) @(posedge aclk);
			t_sck <= 1'b0;
		end
		repeat (4) @(posedge aclk);
		ssel_n <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		for (int a = 0; a < 20; a += 4) rdc(8'(a), 32'h0, ~32'h0);
		chk("read resp", `SPS_RESP_SLVERR, lresp);
		wr(8'h10, 32'h1);
		chk("write resp", `SPS_RESP_SLVERR, lresp);
		wr(`SPS_OFF_CFG, 32'hFF);
		rdc(`SPS_OFF_CFG, 32'h87, 32'hFF);
		wr(`SPS_OFF_DIV, 32'hA5);
		rdc(`SPS_OFF_DIV, 32'hA5, 32'hFF);
		wr(`SPS_OFF_DIV, 32'h01);
		wr(`SPS_OFF_CFG, 32'h00);
	endtask
	task automatic t_master;
		wr(`SPS_OFF_CTRL, 32'h03);
		go(16'h5AA5, 8'h3C);
		rdc(`SPS_OFF_CTRL, 32'h80, 32'h80);
		wr(`SPS_OFF_DATA, 32'h11);
		idle;
		rdc(`SPS_OFF_CTRL, 32'h53, 32'hFF);
		chk("mosi byte", 8'hA5, m_rx);
		chk("sck rises", 8, n_rise);
		chk("sck high cycles", 16, hi_cyc);
		rdc(`SPS_OFF_DATA, 32'h3C, 32'hFF);
		go(16'h12, 8'hC3);
		idle;
		go(16'h34, 8'h99);
		idle;
		rdc(`SPS_OFF_CTRL, 32'h20, 32'h20);
		rdc(`SPS_OFF_DATA, 32'hC3, 32'hFF);
	endtask
	task automatic t_irq;
		chk("irq gated", 0, irq);
		wr(`SPS_OFF_CFG, 32'h80);
		chk("irq raised", 1, irq);
		for (int b = 3; b < 7; b++) begin
			wr(`SPS_OFF_CTRL, 32'h03);
			chk("irq cleared", 0, irq);
			wr(`SPS_OFF_CTRL, 32'h03 | (32'h1 << b));
			chk("irq by software", 1, irq);
		end
		wr(`SPS_OFF_CFG, 32'h00);
		chk("irq masked", 0, irq);
	endtask
	task automatic t_fault;
		wr(`SPS_OFF_CTRL, 32'h03);
		ssel_n <= 1'b0;
		rdc(`SPS_OFF_CTRL, 32'h03, 32'hFF);
		ssel_n <= 1'b1;
		wr(`SPS_OFF_CTRL, 32'h07);
		ssel_n <= 1'b0;
		rdc(`SPS_OFF_CTRL, 32'h0C, 32'hFF);
		chk("sck enable", 1, pins_out.sck_oe_n);
		wr(`SPS_OFF_CTRL, 32'h03);
		rdc(`SPS_OFF_CTRL, 32'h01, 32'hFF);
		ssel_n <= 1'b1;
	endtask
	task automatic t_slave;
		logic [7:0] g;
		wr(`SPS_OFF_CTRL, 32'h01);
		wr(`SPS_OFF_DATA, 32'h96);
		spx(8'h5B, 8, g);
		chk("miso byte", 8'h96, g);
		rdc(`SPS_OFF_DATA, 32'h5B, 32'hFF);
		rdc(`SPS_OFF_CTRL, 32'h41, 32'hFF);
		wr(`SPS_OFF_CTRL, 32'h01);
		spx(8'hFF, 3, g);
		rdc(`SPS_OFF_CTRL, 32'h01, 32'hFF);
		spx(8'h3A, 8, g);
		rdc(`SPS_OFF_DATA, 32'h3A, 32'hFF);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, t_sck, t_mosi} = 4'h0;
		{ssel_n, m_sel_n, s_axi_wstrb} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, tx_b} = 24'h0;
		s_axi_wdata = 32'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_master;
		t_irq;
		t_fault;
		t_slave;
		summarize;
	end
endmodule
